// File: scsi_conn_pkg.sv
// constants and types for the scsi connection-start block
package scsi_conn_pkg;
  // ****************************************
  // clock and times
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 400;
  localparam int CLEAR_NS = 800;
  localparam int FREE_NS = 800;
  localparam int SET_NS = 1800;
  localparam int ARB_NS = 2400;
  localparam int DESKEW_NS = 45;
  localparam int HOLD_NS = 45;
  localparam int NEGATE_NS = 90;
  localparam int RSTHOLD_NS = 25000;
  localparam int SELABORT_US = 200;
  localparam int SELTIMEOUT_MS = 250;
  localparam int POWERUP_MS = 10000;
  localparam int HARDRESET_MS = 250;
  // minimums round up, maximums round down
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FREE_CYC = (FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SET_CYC = SET_NS / CLK_PERIOD_NS;
  localparam int CLEAR_CYC = CLEAR_NS / CLK_PERIOD_NS;
  localparam int ARB_CYC = (ARB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NEGATE_CYC = (NEGATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WINHOLD_CYC = (CLEAR_NS + SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELABORT_CYC = SELABORT_US * 1000 / CLK_PERIOD_NS;
  localparam int SELTIMEOUT_CYC = SELTIMEOUT_MS * 100000;
  localparam int READY_CYC = HARDRESET_MS * 100000;
  localparam int CNT_W = 26;
  // ****************************************
  // states
  // ****************************************
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_FREEWAIT = 8'h02,
    ST_ARB = 8'h04,
    ST_WON = 8'h08,
    ST_LOST = 8'h10,
    ST_SELECTED = 8'h20,
    ST_WAITSEL = 8'h40,
    ST_CONNECTED = 8'h80
  } conn_state_t;
endpackage

// File: scsi_delay_cnt.sv
// cycle counter that flags when a level has stood long enough
`timescale 1ns/1ps
`default_nettype none
module scsi_delay_cnt
  import scsi_conn_pkg::*;
#(
  parameter int LIMIT = 40
) (
  // clock
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // level and result
  input wire logic level,
  output var logic done
);
  logic [CNT_W-1:0] cnt_q;
  assign done = level && (cnt_q >= CNT_W'(LIMIT));
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (!level) begin
        cnt_q <= '0;
      end else if (!done) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: scsi_sel_check.sv
// decides whether the data bus holds a valid selection of this id
`timescale 1ns/1ps
`default_nettype none
module scsi_sel_check (
  // bus view
  input wire logic [7:0] dataIn,
  input wire logic parityIn,
  input wire logic [7:0] ownBit,
  // verdict
  output var logic valid,
  output var logic [7:0] otherBits
);
  function automatic logic [3:0] popcnt(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction
  wire logic parityOk;
  // odd parity over data and parity bit
  assign parityOk = ^{dataIn, parityIn};
  assign otherBits = dataIn & ~ownBit;
  assign valid = parityOk && (popcnt(dataIn) <= 4'h2) && ((dataIn & ownBit) != 8'h00);
endmodule
`default_nettype wire

// File: scsi_arb_sel.sv
// bus free, arbitration and target selection logic
`timescale 1ns/1ps
`default_nettype none
module scsi_arb_sel
  import scsi_conn_pkg::*;
#(
  parameter int SELTIMEOUT = SELTIMEOUT_CYC,
  parameter int READY = READY_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // own identity and user requests
  input wire logic [2:0] ownId,
  input wire logic arbReq,
  input wire logic reqPulse,
  input wire logic [7:0] txData,
  input wire logic release_,
  // bus inputs
  input wire logic busyIn,
  input wire logic selIn,
  input wire logic ioIn,
  input wire logic atnIn,
  input wire logic busRstIn,
  input wire logic [7:0] dataIn,
  input wire logic parityIn,
  // bus outputs, enable low drives the line
  output logic busyOut,
  output logic busyOe_n,
  output logic selOut,
  output logic selOe_n,
  output logic reqOut,
  output logic reqOe_n,
  output logic [7:0] dataOut,
  output logic dataOe_n,
  // status
  output logic busFree,
  output logic arbWon,
  output logic arbLost,
  output logic selected,
  output logic [7:0] initiatorBits,
  output logic atnSeen,
  output logic ready,
  output logic selTimeout
);
  // ****************************************
  // timing detectors
  // ****************************************
  wire logic idleLvl;
  wire logic freeDet;
  wire logic freeDelayDone;
  wire logic arbDone;
  wire logic winHoldDone;
  wire logic selLvl;
  wire logic selDet;
  wire logic selValid;
  wire logic [7:0] otherBits;
  wire logic [7:0] ownBit;
  wire logic higherSeen;
  conn_state_t state_q, state_d;
  logic [CNT_W-1:0] tmr_q;
  logic [CNT_W-1:0] readyCnt_q;
  logic [3:0] reqCnt_q;

  assign ownBit = 8'h01 << ownId;
  assign idleLvl = !busyIn && !selIn;
  assign selLvl = selIn && !busyIn && !ioIn && dataIn[ownId];

  scsi_delay_cnt #(.LIMIT(SETTLE_CYC)) u_free (
    .mclk(mclk), .rst(rst), .ce(ce), .level(idleLvl), .done(freeDet)
  );
  scsi_delay_cnt #(.LIMIT(SETTLE_CYC)) u_sel (
    .mclk(mclk), .rst(rst), .ce(ce), .level(selLvl), .done(selDet)
  );
  scsi_sel_check u_chk (
    .dataIn(dataIn), .parityIn(parityIn), .ownBit(ownBit),
    .valid(selValid), .otherBits(otherBits)
  );

  // ****************************************
  // phase sequencer
  // ****************************************
  // dataIn sees the wired-or of all ids; any bit above ours beats us
  assign higherSeen = (dataIn & ~((ownBit << 1) - 8'h01) & ~ownBit) != 8'h00;
  assign freeDelayDone = tmr_q >= CNT_W'(FREE_CYC);
  assign arbDone = tmr_q >= CNT_W'(ARB_CYC);
  assign winHoldDone = tmr_q >= CNT_W'(WINHOLD_CYC);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (selDet && selValid) begin
          state_d = ST_SELECTED;
        end else if (arbReq && freeDet) begin
          state_d = ST_FREEWAIT;
        end
      end
      ST_FREEWAIT: begin
        // too late past bus set delay, or bus taken: start over
        if (!idleLvl || tmr_q >= CNT_W'(SET_CYC)) begin
          state_d = ST_IDLE;
        end else if (freeDelayDone) begin
          state_d = ST_ARB;
        end
      end
      ST_ARB: begin
        if (selIn) begin
          state_d = ST_LOST;
        end else if (arbDone) begin
          state_d = higherSeen ? ST_LOST : ST_WON;
        end
      end
      ST_WON: begin
        if (winHoldDone && release_) begin
          state_d = ST_IDLE;
        end
      end
      ST_LOST: begin
        state_d = ST_IDLE;
      end
      ST_SELECTED: begin
        state_d = ST_WAITSEL;
      end
      ST_WAITSEL: begin
        if (!selIn) begin
          state_d = ST_CONNECTED;
        end else if (release_) begin
          state_d = ST_IDLE;
        end
      end
      ST_CONNECTED: begin
        if (release_) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (busRstIn) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      tmr_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      tmr_q <= (state_d != state_q) ? '0 : tmr_q + 1'b1;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  wire logic driveBusy;
  wire logic driveId;
  wire logic reqAllowed;
  // sync pulses: REQ high then negated, data held through both windows
  assign reqAllowed = (state_q == ST_CONNECTED) && (reqCnt_q == 4'h0) && reqPulse;
  assign driveBusy = (state_d == ST_ARB) || (state_d == ST_WON) ||
    (state_d == ST_SELECTED) || (state_d == ST_WAITSEL) || (state_d == ST_CONNECTED);
  assign driveId = (state_d == ST_ARB) || (state_d == ST_WON);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busyOut <= 1'b0;
      busyOe_n <= 1'b1;
      selOut <= 1'b0;
      selOe_n <= 1'b1;
      reqOut <= 1'b0;
      reqOe_n <= 1'b1;
      dataOut <= 8'h00;
      dataOe_n <= 1'b1;
      reqCnt_q <= 4'h0;
    end else if (ce) begin
      busyOut <= driveBusy;
      busyOe_n <= !driveBusy;
      selOut <= (state_d == ST_WON);
      selOe_n <= !(state_d == ST_WON);
      if (state_d != ST_CONNECTED) begin
        reqOut <= 1'b0;
        reqOe_n <= 1'b1;
        reqCnt_q <= 4'h0;
        dataOut <= driveId ? ownBit : 8'h00;
        dataOe_n <= !driveId;
      end else if (reqAllowed) begin
        reqOut <= 1'b1;
        reqOe_n <= 1'b0;
        dataOut <= txData;
        dataOe_n <= 1'b0;
        reqCnt_q <= 4'(NEGATE_CYC + HOLD_CYC);
      end else begin
        if (reqCnt_q == 4'(NEGATE_CYC + 1)) begin
          reqOut <= 1'b0;
        end
        if (reqCnt_q != 4'h0) begin
          reqCnt_q <= reqCnt_q - 4'h1;
        end
      end
    end
  end

  // ****************************************
  // status
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busFree <= 1'b0;
      arbWon <= 1'b0;
      arbLost <= 1'b0;
      selected <= 1'b0;
      initiatorBits <= 8'h00;
      atnSeen <= 1'b0;
      ready <= 1'b0;
      readyCnt_q <= '0;
      selTimeout <= 1'b0;
    end else if (ce) begin
      busFree <= freeDet;
      arbWon <= (state_d == ST_WON);
      arbLost <= (state_d == ST_LOST);
      selected <= (state_d == ST_SELECTED) || (state_d == ST_WAITSEL) ||
        (state_d == ST_CONNECTED);
      if (state_d == ST_SELECTED) begin
        initiatorBits <= otherBits;
        atnSeen <= atnIn;
      end
      // bus reset restarts the readiness count, like a hard reset
      if (busRstIn) begin
        readyCnt_q <= '0;
        ready <= 1'b0;
      end else if (readyCnt_q >= CNT_W'(READY)) begin
        ready <= 1'b1;
      end else begin
        readyCnt_q <= readyCnt_q + 1'b1;
      end
      // winner flags selTimeout after SELTIMEOUT cycles in won; release_ can end the wait once the win hold is done
      selTimeout <= (state_q == ST_WON) && (tmr_q >= CNT_W'(SELTIMEOUT));
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // outputs are registered, so most checks look one edge after the decision
  AST_SEL_HOLD: assert property (@(posedge mclk) disable iff (rst)
    $rose(selOut) |-> selOut [*8]) else $error("sel dropped too early");
  AST_NO_REQ_UNDER_SEL: assert property (@(posedge mclk) disable iff (rst)
    (selIn && state_q == ST_WAITSEL) |=> !$rose(reqOut)) else $error("req while sel");
  AST_BSY_AFTER_SEL: assert property (@(posedge mclk) disable iff (rst || !ce)
    (state_q == ST_SELECTED && !busRstIn) |-> ##1 busyOut) else $error("bsy late on selection");
  AST_ARB_WAIT: assert property (@(posedge mclk) disable iff (rst || !ce)
    $rose(selOut) |-> $past(busyOut, ARB_CYC))
    else $error("arbitration judged early");
  AST_FREE_WAIT: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_FREEWAIT) |-> busyOe_n && dataOe_n) else $error("drove in free delay");
  AST_LOSE_RELEASE: assert property (@(posedge mclk) disable iff (rst || !ce)
    (state_q == ST_ARB && selIn && !busRstIn) |-> ##[1:2] busyOe_n)
    else $error("loser kept bsy");
  AST_FREE_DETECT: assert property (@(posedge mclk) disable iff (rst || !ce)
    freeDet |-> $past(idleLvl, SETTLE_CYC)) else $error("free seen without idle");
  AST_REQ_NEG: assert property (@(posedge mclk) disable iff (rst || !ce)
    $fell(reqOut) |-> !reqOut [*8]) else $error("req negation too short");
  AST_RST_CLEAR: assert property (@(posedge mclk) disable iff (rst || !ce)
    busRstIn |=> busyOe_n && selOe_n && dataOe_n) else $error("bus reset not cleared");
  COV_WIN: cover property (@(posedge mclk) disable iff (rst) $rose(arbWon));
  COV_LOSE: cover property (@(posedge mclk) disable iff (rst) $rose(arbLost));
  COV_SELECT: cover property (@(posedge mclk) disable iff (rst) $rose(selected));
  COV_REQ: cover property (@(posedge mclk) disable iff (rst) $rose(reqOut));
endmodule
`default_nettype wire

// File: scsi_bus_host.sv
// far-side bus model: an initiator that arbitrates, selects and resets the bus
`timescale 1ns/1ps
`default_nettype none
module scsi_bus_host (
  // clock and bus as seen
  input wire logic mclk,
  input wire logic busyBus,
  input wire logic selBus,
  // own drive, a released line reads false through the terminators
  output logic mBusy,
  output logic mSel,
  output logic mAtn,
  output logic mRst,
  output logic mParity,
  output logic [7:0] mData
);
  initial begin
    mBusy = 1'h0;
    mSel = 1'h0;
    mAtn = 1'h0;
    mRst = 1'h0;
    mParity = 1'h0;
    mData = 8'h00;
  end
  // ****************************************
  // bus phases
  // ****************************************
  task automatic arbitrate(input logic [7:0] idBit);
    int n;
    n = 0;
    for (int i = 0; i < 2000 && n < 40; i++) begin
      @(posedge mclk);
      n = (busyBus || selBus) ? 0 : n + 1;
    end
    repeat (80) @(posedge mclk);
    mBusy <= 1'h1;
    mData <= idBit;
    repeat (240) @(posedge mclk);
    mSel <= 1'h1;
    repeat (120) @(posedge mclk);
    mSel <= 1'h0;
    mBusy <= 1'h0;
    mData <= 8'h00;
  endtask
  task automatic select(input logic [7:0] bits, input logic badPar, output logic answered);
    @(posedge mclk);
    mBusy <= 1'h1;
    mSel <= 1'h1; // io never driven
    mData <= bits;
    mAtn <= 1'h1;
    mParity <= (~^bits) ^ badPar;
    repeat (9) @(posedge mclk);
    mBusy <= 1'h0;
    repeat (40) @(posedge mclk);
    answered = 1'h0;
    // answer window kept short; a late target still shows up well inside it
    for (int i = 0; i < 200 && !answered; i++) begin
      @(posedge mclk);
      answered = busyBus;
    end
    repeat (9) @(posedge mclk);
    mSel <= 1'h0;
    mAtn <= 1'h0;
    mData <= 8'h00;
  endtask
  task automatic busReset();
    @(posedge mclk);
    mRst <= 1'h1;
    repeat (2500) @(posedge mclk);
    mRst <= 1'h0;
  endtask
endmodule
`default_nettype wire

// File: scsi_arb_sel_tb.sv
// self-checking bench for the connection-start block
`timescale 1ns/1ps
`default_nettype none
module scsi_arb_sel_tb
  import scsi_conn_pkg::*;
;
  logic mclk, rst, ce, ioIn, arbReq, reqPulse, release_, lostSeen, reqEarly;
  logic [2:0] ownId;
  logic [7:0] txData, dataOut, initiatorBits, mData, dataIn;
  logic busyOut, busyOe_n, selOut, selOe_n, reqOut, reqOe_n, dataOe_n;
  logic busFree, arbWon, arbLost, selected, atnSeen, ready, selTimeout;
  logic mBusy, mSel, mAtn, mRst, mParity, busyIn, selIn;
  int bad_count = 0;
  int check_count = 0;
  // wired-or bus, released lines read false
  assign busyIn = mBusy | (~busyOe_n & busyOut);
  assign selIn = mSel | (~selOe_n & selOut);
  assign dataIn = mData | (dataOe_n ? 8'h00 : dataOut);
  scsi_arb_sel #(.SELTIMEOUT(200), .READY(100)) dut_u (.mclk(mclk), .rst(rst), .ce(ce),
    .ownId(ownId), .arbReq(arbReq), .reqPulse(reqPulse), .txData(txData),
    .release_(release_), .busyIn(busyIn), .selIn(selIn), .ioIn(ioIn), .atnIn(mAtn),
    .busRstIn(mRst), .dataIn(dataIn), .parityIn(mParity), .busyOut(busyOut),
    .busyOe_n(busyOe_n), .selOut(selOut), .selOe_n(selOe_n), .reqOut(reqOut),
    .reqOe_n(reqOe_n), .dataOut(dataOut), .dataOe_n(dataOe_n), .busFree(busFree),
    .arbWon(arbWon), .arbLost(arbLost), .selected(selected),
    .initiatorBits(initiatorBits), .atnSeen(atnSeen), .ready(ready),
    .selTimeout(selTimeout));
  scsi_bus_host host_u (.mclk(mclk), .busyBus(busyIn), .selBus(selIn), .mBusy(mBusy),
    .mSel(mSel), .mAtn(mAtn), .mRst(mRst), .mParity(mParity), .mData(mData));
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // arbLost is a one-cycle pulse, so latch it
  always @(negedge mclk) begin
    if (arbLost) lostSeen <= 1'h1;
    if (selIn && reqOut && !reqOe_n) reqEarly <= 1'h1;
  end
  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic scWin(input logic early);
    int n;
    @(posedge mclk);
    ownId <= 3'h6;
    arbReq <= 1'h1;
    for (n = 0; n < 400 && busyOe_n; n++) @(negedge mclk);
    check("free wait", n >= FREE_CYC, 1'h1);
    check("set limit", n <= SET_CYC, 1'h1);
    check("own id", dataOe_n ? 8'hFF : dataOut, 8'h40);
    for (n = 0; n < 400 && selOe_n; n++) @(negedge mclk);
    check("arb delay", n >= ARB_CYC && n < 400, 1'h1);
    check("won", arbWon, 1'h1);
    @(posedge mclk);
    arbReq <= 1'h0;
    release_ <= early;
    for (n = 0; n < WINHOLD_CYC - 2; n++) begin
      @(negedge mclk);
      check("sel hold", {busyOe_n, selOe_n, dataOe_n, selTimeout, busFree}, 5'h00);
    end
    for (n = 0; n < 300 && !early && !selTimeout; n++) @(negedge mclk);
    check("sel timeout", n < 300, 1'h1);
    @(posedge mclk);
    release_ <= 1'h1;
    for (n = 0; n < 20 && !busyOe_n; n++) @(negedge mclk);
    check("released", {busyOe_n, selOe_n, dataOe_n}, 3'h7);
    @(posedge mclk);
    release_ <= 1'h0;
    for (n = 0; n < 100 && !busFree; n++) @(negedge mclk);
    check("free detect", n >= SETTLE_CYC - 1 && n <= SETTLE_CYC + 2, 1'h1);
  endtask
  task automatic scLose();
    int n;
    @(posedge mclk);
    ownId <= 3'h3;
    lostSeen <= 1'h0;
    fork
      host_u.arbitrate(8'h80);
      begin
        // raise bsy on the host's edge, so its sel lands as our arbitration delay ends
        repeat (38) @(posedge mclk);
        arbReq <= 1'h1;
        for (n = 0; n < 800 && !selIn; n++) @(negedge mclk);
        repeat (CLEAR_CYC) @(negedge mclk);
        check("loser off", {busyOe_n, dataOe_n, arbWon, lostSeen}, 4'hD);
        @(posedge mclk);
        arbReq <= 1'h0;
      end
    join
  endtask
  task automatic scSelect(input logic [7:0] bits, input logic badPar, input logic expAns);
    logic ans;
    @(posedge mclk);
    ownId <= 3'h2;
    host_u.select(bits, badPar, ans);
    check("answer", ans, expAns);
    check("selected", selected, expAns);
  endtask
  task automatic scConnect();
    int n;
    int k;
    // request raised early on purpose: it must wait for sel to fall
    @(posedge mclk);
    reqPulse <= 1'h1;
    txData <= 8'hA5;
    reqEarly <= 1'h0;
    scSelect(8'h84, 1'h0, 1'h1);
    check("init id", initiatorBits, 8'h80);
    check("atn", atnSeen, 1'h1);
    for (n = 0; n < 50 && !reqOut; n++) @(negedge mclk);
    @(posedge mclk);
    txData <= 8'h3C;
    for (n = 1; n < 30; n++) begin
      @(negedge mclk);
      if (!reqOut) break;
      check("hold data", dataOut, 8'hA5);
    end
    check("req width", n >= HOLD_CYC, 1'h1);
    for (k = 0; k < 40 && !reqOut; k++) @(negedge mclk);
    check("req negated", k >= NEGATE_CYC && k < 40, 1'h1);
    check("next byte", dataOut, 8'h3C);
    check("req in sel", reqEarly, 1'h0);
    @(posedge mclk);
    reqPulse <= 1'h0;
    fork
      host_u.busReset();
      begin
        repeat (3) @(negedge mclk);
        check("bus reset", {busyOe_n, reqOe_n, dataOe_n, selected, ready}, 5'h1C);
      end
    join
    for (n = 0; n < 150 && !ready; n++) @(negedge mclk);
    check("ready again", ready, 1'h1);
  endtask
  task automatic scFreeze();
    // enable low: a pending arbitration request must not move anything
    @(posedge mclk);
    ce <= 1'h0;
    arbReq <= 1'h1;
    repeat (200) @(negedge mclk);
    check("frozen", {busyOe_n, arbWon, busFree, ready}, 4'hB);
    @(posedge mclk);
    arbReq <= 1'h0;
    @(posedge mclk);
    ce <= 1'h1;
    repeat (2) @(negedge mclk);
    check("thawed", {busyOe_n, arbWon, busFree, ready}, 4'hB);
  endtask
  initial begin
    int n;
    rst = 1'h1;
    arbReq = 1'h0;
    reqPulse = 1'h0;
    release_ = 1'h0;
    ownId = 3'h0;
    txData = 8'h00;
    lostSeen = 1'h0;
    reqEarly = 1'h0;
    ce = 1'h1;
    ioIn = 1'h0;
    repeat (10) @(posedge mclk);
    rst <= 1'h0;
    @(negedge mclk);
    check("idle drive", {busyOe_n, selOe_n, reqOe_n, dataOe_n, selected, arbWon, ready},
      7'h78);
    for (n = 1; n < 200 && !ready; n++) @(negedge mclk);
    check("ready time", n >= 95 && n <= 105, 1'h1);
    scWin(1'h1);
    scWin(1'h0);
    scLose();
    scSelect(8'h84, 1'h1, 1'h0);
    scSelect(8'h8C, 1'h0, 1'h0);
    scSelect(8'h81, 1'h0, 1'h0);
    ioIn <= 1'h1;
    scSelect(8'h84, 1'h0, 1'h0);
    ioIn <= 1'h0;
    scConnect();
    scFreeze();
    summarize();
  end
endmodule
`default_nettype wire
